/* hdl/pcdl_ctrl.sv */
// Purpose: Link layer debug and error control registers with injectors
// Assumes: AHB-Lite slave at 40 MHz, zero wait state, single words
// Notes: Strobe outputs qualify the beat they arrive with
// What this block does
// - Control bit doubles acknowledgement rate
// - Override enable edge latches pending length request
// - Matching TLP gets replacement STP length
// - Length counts token, header, payload, ECRC, LCRC
// - Override ignored at 2.5 and 5G
// - Prefix parity edge injects on next TLP
// - Early forwarding unless disable bit set
// - Gap edge drops one valid inside TLP
// - Malformed edge deletes next TLP end
// - LCRC edge inverts bit 0 at end
// - Block TLPs while link down unless disabled
// - TLP inhibit bumps received sequence number
// - ACK/NAK inhibit discards those DLLPs
// - Report disable suppresses post-sequence parity reports
// - Parity-errored TLPs nullified unless handling disabled
// - Post-sequence parity edge injects next TLP
// - Pre-sequence parity edge injects next TLP
// - Double-bit report disable suppresses reporting
// - Double-bit handling nullifies replayed TLPs
// - Double-bit edge corrupts next RAM write
// - Single-bit correction off means uncorrectable
// - Single-bit edge corrupts next RAM write
// - Sticky post-sequence parity flag, write one clears
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps

module pcdl_ctrl (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [pcdl_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link state
  input wire pcdl_pkg::pcdl_rate_type link_rate,
  input wire logic link_up_indication,
  // Transmit TLP stream
  input wire logic tx_tlp_start,
  input wire logic tx_tlp_end,
  input wire logic tx_in_tlp,
  input wire logic tx_word_valid_in,
  input wire logic [pcdl_pkg::HDR_W-1:0] tx_hdr_dw,
  input wire logic [pcdl_pkg::LEN_W-1:0] tx_payload_dw,
  input wire logic tx_ecrc_present,
  output logic link_tx_word_valid,
  output logic tx_tlp_end_out,
  output logic lcrc_bit0_invert,
  output logic [pcdl_pkg::LEN_W-1:0] stp_len_field,
  output logic stp_len_valid,
  // Transmit parity injection and handling
  output logic prefix_parity_fault,
  output logic pre_seq_parity_fault,
  output logic post_seq_parity_fault,
  input wire logic post_seq_parity_err,
  output logic post_seq_parity_nullify,
  output logic post_seq_parity_report,
  // Replay buffer ECC
  input wire logic replay_ram_write,
  output logic replay_single_flip,
  output logic replay_double_flip,
  input wire logic replay_single_err,
  input wire logic replay_double_err,
  output logic replay_single_correct,
  output logic replay_err_nullify,
  output logic replay_double_report,
  output logic replay_single_report,
  // Receive path
  input wire logic rx_tlp_valid,
  input wire logic [pcdl_pkg::SEQ_W-1:0] rx_tlp_seq,
  output logic rx_tlp_accept,
  output logic [pcdl_pkg::SEQ_W-1:0] rx_tlp_seq_out,
  input wire logic rx_acknak_valid,
  output logic rx_acknak_accept,
  output logic rx_early_forward_en,
  // Acknowledge scheduling
  output logic ack_double_rate
);
  import pcdl_pkg::*;

  logic [31:0] ack_ctrl_reg;
  logic [31:0] tx_ovr_reg;
  logic [31:0] err_ctrl_reg;
  logic post_seq_parity_flag;
  logic [ADDR_W-1:0] addr_reg;
  logic wr_pend_reg;
  logic addr_phase;
  logic stp_take;
  logic [31:0] rd_value;

  pcdl_inj_if #(.N(INJ_N)) inj ();

  // Zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & htrans[1] & hready;

  // Capture address phase for a following write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= '0;
      wr_pend_reg <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        addr_reg <= haddr;
      end
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (haddr == OFS_ACK) begin
      rd_value = ack_ctrl_reg;
    end else if (haddr == OFS_TX) begin
      rd_value = tx_ovr_reg;
    end else if (haddr == OFS_CTRL) begin
      rd_value = err_ctrl_reg;
    end else if (haddr == OFS_STAT) begin
      rd_value[STAT_POST_PAR_BIT] = post_seq_parity_flag;
    end
  end

  // Read data taken at address phase, stands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      hrdata <= rd_value;
    end
  end

  // Control register writes; reserved bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_ctrl_reg <= RST_ACK;
      tx_ovr_reg <= RST_TX;
      err_ctrl_reg <= RST_CTRL;
    end else if (wr_pend_reg) begin
      if (addr_reg == OFS_ACK) begin
        ack_ctrl_reg <= hwdata & MASK_ACK;
      end else if (addr_reg == OFS_TX) begin
        tx_ovr_reg <= hwdata & MASK_TX;
      end else if (addr_reg == OFS_CTRL) begin
        err_ctrl_reg <= hwdata & MASK_CTRL;
      end
    end
  end

  // Sticky status; detection wins over a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_seq_parity_flag <= 1'b0;
    end else if (post_seq_parity_report) begin
      post_seq_parity_flag <= 1'b1;
    end else if (wr_pend_reg && addr_reg == OFS_STAT && hwdata[STAT_POST_PAR_BIT]) begin
      post_seq_parity_flag <= 1'b0;
    end
  end

  // Arm levels straight from the register bits
  assign inj.arm[INJ_STP] = tx_ovr_reg[STP_EN_BIT];
  assign inj.arm[INJ_PFX] = err_ctrl_reg[PFX_PAR_BIT];
  assign inj.arm[INJ_GAP] = err_ctrl_reg[GAP_BIT];
  assign inj.arm[INJ_MALF] = err_ctrl_reg[MALF_BIT];
  assign inj.arm[INJ_LCRC] = err_ctrl_reg[LCRC_BIT];
  assign inj.arm[INJ_POST] = err_ctrl_reg[POST_ARM_BIT];
  assign inj.arm[INJ_PRE] = err_ctrl_reg[PRE_ARM_BIT];
  assign inj.arm[INJ_DBL] = err_ctrl_reg[DBL_ARM_BIT];
  assign inj.arm[INJ_SGL] = err_ctrl_reg[SGL_ARM_BIT];

  pcdl_oneshot #(.N(INJ_N)) u_oneshot (
    .hclk(hclk),
    .hresetn(hresetn),
    .inj(inj)
  );

  pcdl_stp_len u_stp_len (
    .hclk(hclk),
    .hresetn(hresetn),
    .tx_tlp_start(tx_tlp_start),
    .tx_hdr_dw(tx_hdr_dw),
    .tx_payload_dw(tx_payload_dw),
    .tx_ecrc_present(tx_ecrc_present),
    .link_rate(link_rate),
    .override_pending(inj.pending[INJ_STP]),
    .override_match(tx_ovr_reg[STP_MATCH_LSB +: LEN_W]),
    .override_new(tx_ovr_reg[STP_NEW_LSB +: LEN_W]),
    .override_take(stp_take),
    .stp_len_field(stp_len_field),
    .stp_len_valid(stp_len_valid)
  );

  // Consume each pending request at its opportunity
  assign inj.take[INJ_STP] = stp_take;
  assign inj.take[INJ_PFX] = inj.pending[INJ_PFX] & tx_tlp_start;
  assign inj.take[INJ_GAP] = inj.pending[INJ_GAP] & tx_in_tlp & tx_word_valid_in;
  assign inj.take[INJ_MALF] = inj.pending[INJ_MALF] & tx_tlp_end;
  assign inj.take[INJ_LCRC] = inj.pending[INJ_LCRC] & tx_tlp_end;
  assign inj.take[INJ_POST] = inj.pending[INJ_POST] & tx_tlp_start;
  assign inj.take[INJ_PRE] = inj.pending[INJ_PRE] & tx_tlp_start;
  assign inj.take[INJ_DBL] = inj.pending[INJ_DBL] & replay_ram_write;
  assign inj.take[INJ_SGL] = inj.pending[INJ_SGL] & replay_ram_write;

  // Transmit corruptions on the consuming beat
  assign prefix_parity_fault = inj.take[INJ_PFX];
  assign post_seq_parity_fault = inj.take[INJ_POST];
  assign pre_seq_parity_fault = inj.take[INJ_PRE];
  // A one-cycle hole may underflow the physical layer
  assign link_tx_word_valid = tx_word_valid_in & ~inj.take[INJ_GAP];
  assign tx_tlp_end_out = tx_tlp_end & ~inj.take[INJ_MALF];
  assign lcrc_bit0_invert = inj.take[INJ_LCRC];
  // Flips only show if that TLP is later replayed
  assign replay_double_flip = inj.take[INJ_DBL];
  assign replay_single_flip = inj.take[INJ_SGL];

  // Parity handling and reporting, prefix errors included
  assign post_seq_parity_nullify = post_seq_parity_err & ~err_ctrl_reg[POST_HDL_OFF_BIT];
  assign post_seq_parity_report = post_seq_parity_err & ~err_ctrl_reg[POST_REP_OFF_BIT];

  // Replay ECC: single-bit demoted when correction is off
  assign replay_single_correct = replay_single_err & ~err_ctrl_reg[SGL_CORR_OFF_BIT];
  assign replay_err_nullify = (replay_double_err | (replay_single_err & err_ctrl_reg[SGL_CORR_OFF_BIT]))
                              & ~err_ctrl_reg[DBL_HDL_OFF_BIT];
  assign replay_double_report = (replay_double_err | (replay_single_err & err_ctrl_reg[SGL_CORR_OFF_BIT]))
                                & ~err_ctrl_reg[DBL_REP_OFF_BIT];
  assign replay_single_report = replay_single_correct & ~err_ctrl_reg[SGL_REP_OFF_BIT];

  // Receive path gating
  assign rx_tlp_accept = rx_tlp_valid & (err_ctrl_reg[GATE_OFF_BIT] | link_up_indication);
  // Seen as one past the expected number, so the partner replays
  assign rx_tlp_seq_out = err_ctrl_reg[TLP_INH_BIT] ? rx_tlp_seq + SEQ_STEP[SEQ_W-1:0] : rx_tlp_seq;
  assign rx_acknak_accept = rx_acknak_valid & ~err_ctrl_reg[ACKNAK_INH_BIT];
  assign rx_early_forward_en = ~err_ctrl_reg[EARLY_FWD_OFF_BIT];
  assign ack_double_rate = ack_ctrl_reg[ACK_RATE_BIT];

endmodule : pcdl_ctrl

/* hdl/pcdl_oneshot.sv */
// Purpose: Rising-edge one-shot request latches, one per injector
// Assumes: arm comes from a register on the same clock
// Notes: A new edge in the cycle of a take keeps the request
`timescale 1ns/1ps

module pcdl_oneshot #(
  parameter int N = 9
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Injector carrier
  pcdl_inj_if.shot inj
);

  logic [N-1:0] arm_prev_reg;
  logic [N-1:0] pend_reg;

  assign inj.pending = pend_reg;

  // Per-slot edge detect and pending latch
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_slot
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          arm_prev_reg[gi] <= 1'b0;
          pend_reg[gi] <= 1'b0;
        end else begin
          arm_prev_reg[gi] <= inj.arm[gi];
          // Set beats take so a fresh edge is never lost
          pend_reg[gi] <= (inj.arm[gi] & ~arm_prev_reg[gi]) | (pend_reg[gi] & ~inj.take[gi]);
        end
      end
    end
  endgenerate

endmodule : pcdl_oneshot

/* hdl/pcdl_stp_len.sv */
// Purpose: Computes the framed TLP length for the 128b/130b STP token
// Assumes: Header and payload sizes valid with tx_tlp_start
// Notes: Override applies only at 8G and above
`timescale 1ns/1ps

module pcdl_stp_len (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // TLP description at start
  input wire logic tx_tlp_start,
  input wire logic [pcdl_pkg::HDR_W-1:0] tx_hdr_dw,
  input wire logic [pcdl_pkg::LEN_W-1:0] tx_payload_dw,
  input wire logic tx_ecrc_present,
  input wire pcdl_pkg::pcdl_rate_type link_rate,
  // Override control
  input wire logic override_pending,
  input wire logic [pcdl_pkg::LEN_W-1:0] override_match,
  input wire logic [pcdl_pkg::LEN_W-1:0] override_new,
  // Results
  output logic override_take,
  output logic [pcdl_pkg::LEN_W-1:0] stp_len_field,
  output logic stp_len_valid
);
  import pcdl_pkg::*;

  logic [LEN_W-1:0] computed_len;
  logic framed_rate;

  // Token, header, payload, ECRC, LCRC; EDB never counted
  assign computed_len = STP_TOKEN_DW + LEN_W'(tx_hdr_dw) + tx_payload_dw
                        + LEN_W'(tx_ecrc_present) + LCRC_DW;
  // Lower rates carry no length, so the override is ignored
  assign framed_rate = (link_rate == RATE_8G) || (link_rate == RATE_16G);
  assign override_take = tx_tlp_start & framed_rate & override_pending
                         & (computed_len == override_match);

  // Field register, replaced when the override fires
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stp_len_field <= '0;
      stp_len_valid <= 1'b0;
    end else begin
      stp_len_valid <= tx_tlp_start & framed_rate;
      if (tx_tlp_start) begin
        stp_len_field <= override_take ? override_new : computed_len;
      end
    end
  end

endmodule : pcdl_stp_len

/* inc/pcdl_inj_if.sv */
// Purpose: Carries injector arm levels, take strobes and pending flags
// Assumes: One clock domain
// Notes: ctrl side drives arm and take, shot side reports pending
`timescale 1ns/1ps

interface pcdl_inj_if #(parameter int N = 9);
  logic [N-1:0] arm;
  logic [N-1:0] take;
  logic [N-1:0] pending;
  modport ctrl (output arm, output take, input pending);
  modport shot (input arm, input take, output pending);
endinterface : pcdl_inj_if

/* inc/pcdl_pkg.sv */
// Purpose: Shared constants for the link layer debug control block
// Assumes: 32-bit AHB-Lite register access, byte addresses below
// Notes: All fields reset to zero

package pcdl_pkg;

  // Register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_ACK = 12'h384;
  localparam logic [11:0] OFS_TX = 12'h38C;
  localparam logic [11:0] OFS_CTRL = 12'h390;
  localparam logic [11:0] OFS_STAT = 12'h394;

  // Reset values and writable masks
  localparam logic [31:0] RST_ACK = 32'h0000_0000;
  localparam logic [31:0] RST_TX = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] MASK_ACK = 32'h0000_0001;
  localparam logic [31:0] MASK_TX = 32'h87FF_07FF;
  localparam logic [31:0] MASK_CTRL = 32'h0377_7177;

  // Field positions
  localparam int ACK_RATE_BIT = 0;
  localparam int STP_EN_BIT = 31;
  localparam int STP_NEW_LSB = 16;
  localparam int STP_MATCH_LSB = 0;
  localparam int LEN_W = 11;
  localparam int PFX_PAR_BIT = 25;
  localparam int EARLY_FWD_OFF_BIT = 24;
  localparam int GAP_BIT = 22;
  localparam int MALF_BIT = 21;
  localparam int LCRC_BIT = 20;
  localparam int GATE_OFF_BIT = 18;
  localparam int TLP_INH_BIT = 17;
  localparam int ACKNAK_INH_BIT = 16;
  localparam int POST_REP_OFF_BIT = 14;
  localparam int POST_HDL_OFF_BIT = 13;
  localparam int POST_ARM_BIT = 12;
  localparam int PRE_ARM_BIT = 8;
  localparam int DBL_REP_OFF_BIT = 6;
  localparam int DBL_HDL_OFF_BIT = 5;
  localparam int DBL_ARM_BIT = 4;
  localparam int SGL_REP_OFF_BIT = 2;
  localparam int SGL_CORR_OFF_BIT = 1;
  localparam int SGL_ARM_BIT = 0;
  localparam int STAT_POST_PAR_BIT = 19;

  // One-shot injector slots
  localparam int INJ_N = 9;
  localparam int INJ_STP = 0;
  localparam int INJ_PFX = 1;
  localparam int INJ_GAP = 2;
  localparam int INJ_MALF = 3;
  localparam int INJ_LCRC = 4;
  localparam int INJ_POST = 5;
  localparam int INJ_PRE = 6;
  localparam int INJ_DBL = 7;
  localparam int INJ_SGL = 8;

  // Framing length pieces in dwords, then header and sequence widths and sequence step
  localparam logic [LEN_W-1:0] STP_TOKEN_DW = 11'h001;
  localparam logic [LEN_W-1:0] LCRC_DW = 11'h001;
  localparam int HDR_W = 3;
  localparam logic [31:0] SEQ_STEP = 32'h0000_0001;
  localparam int SEQ_W = 12;

  // Link rate code
  typedef enum logic [1:0] {RATE_2G5, RATE_5G, RATE_8G, RATE_16G} pcdl_rate_type;

endpackage : pcdl_pkg

/* test/pcdl_ahb_host.sv */
// Purpose: AHB-Lite master standing in for software at the registers
// Assumes: Single whole-word transfers, slave answers OKAY
// Notes: The bench calls xfer hierarchically
`timescale 1ns/1ps

module pcdl_ahb_host (
  // Clock
  input wire logic hclk,
  // Master outputs
  output logic hsel,
  output logic [pcdl_pkg::ADDR_W-1:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // One transfer; waits as long as the slave stalls
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? wd : ~hwdata; // Stale data never looks valid
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : pcdl_ahb_host

/* test/pcdl_ctrl_checker.sv */
// Purpose: Port-level assertions for the link layer debug control
// Assumes: One clock, hresetn async active low
// Notes: Bound to every pcdl_ctrl instance
`timescale 1ns/1ps

module pcdl_ctrl_checker (
  // Clock, reset and bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [pcdl_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  // Levels
  input wire logic ack_double_rate,
  input wire logic rx_early_forward_en,
  input wire pcdl_pkg::pcdl_rate_type link_rate,
  // Strobes and their opportunities
  input wire logic tx_tlp_start,
  input wire logic tx_tlp_end,
  input wire logic tx_tlp_end_out,
  input wire logic lcrc_bit0_invert,
  input wire logic stp_len_valid,
  input wire logic prefix_parity_fault,
  input wire logic pre_seq_parity_fault,
  input wire logic post_seq_parity_fault,
  input wire logic replay_ram_write,
  input wire logic replay_single_flip,
  input wire logic replay_double_flip,
  input wire logic rx_acknak_valid,
  input wire logic rx_acknak_accept
);
  import pcdl_pkg::*;
  logic wr_reg;
  logic [ADDR_W-1:0] adr_reg;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Remember a write address phase for its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= 1'b0;
      adr_reg <= '0;
    end else begin
      wr_reg <= hsel && htrans[1] && hready && hwrite;
      adr_reg <= haddr;
    end
  end

  a_bus_always_ready: assert property (hreadyout) else $error("slave stalled");
  a_ack_rate_write: assert property (
    wr_reg && adr_reg == OFS_ACK |=> ack_double_rate == $past(hwdata[0])) else $error("ack rate wrong");
  a_early_fwd_write: assert property (
    wr_reg && adr_reg == OFS_CTRL |=> rx_early_forward_en == !$past(hwdata[EARLY_FWD_OFF_BIT]))
    else $error("early forward wrong");
  a_lcrc_on_end: assert property (lcrc_bit0_invert |-> tx_tlp_end) else $error("lcrc off end");
  a_end_not_invented: assert property (tx_tlp_end_out |-> tx_tlp_end) else $error("end invented");
  a_parity_on_start: assert property (
    prefix_parity_fault || pre_seq_parity_fault || post_seq_parity_fault |-> tx_tlp_start)
    else $error("parity fault off start");
  a_flip_on_write: assert property (
    replay_single_flip || replay_double_flip |-> replay_ram_write) else $error("flip off write");
  a_stp_fast_only: assert property (
    stp_len_valid |-> $past(tx_tlp_start) && $past(link_rate) >= RATE_8G) else $error("stp at slow rate");
  a_acknak_needs_valid: assert property (rx_acknak_accept |-> rx_acknak_valid) else $error("acknak ghost");

  // Main scenarios reached
  c_lcrc: cover property (lcrc_bit0_invert);
  c_stp: cover property (stp_len_valid);
  c_ctrl_write: cover property (wr_reg && adr_reg == OFS_CTRL);
endmodule : pcdl_ctrl_checker

bind pcdl_ctrl pcdl_ctrl_checker u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .ack_double_rate,
  .rx_early_forward_en, .link_rate, .tx_tlp_start, .tx_tlp_end, .tx_tlp_end_out, .lcrc_bit0_invert,
  .stp_len_valid, .prefix_parity_fault, .pre_seq_parity_fault, .post_seq_parity_fault, .replay_ram_write,
  .replay_single_flip, .replay_double_flip, .rx_acknak_valid, .rx_acknak_accept
);

/* test/pcdl_ctrl_tb.sv */
// Purpose: Self-checking bench for the link layer debug control
// Assumes: Zero wait state bus, comb strobes sampled mid-cycle
// Notes: Random data from a fixed-seed LFSR
`timescale 1ns/1ps

module pcdl_ctrl_tb;
  import pcdl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, link_up_indication, tx_ecrc_present, rx_tlp_valid, rx_acknak_valid;
  logic [ADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, tx_hdr_dw;
  logic [31:0] hwdata, hrdata, rd, rnd;
  logic [10:0] tx_payload_dw, stp_len_field, nw;
  logic [11:0] rx_tlp_seq, rx_tlp_seq_out;
  logic [7:0] stim, inj;
  logic [5:0] errv;
  pcdl_rate_type link_rate;
  wire tx_tlp_start, tx_tlp_end, tx_in_tlp, tx_word_valid_in, replay_ram_write;
  wire post_seq_parity_err, replay_double_err, replay_single_err;
  logic link_tx_word_valid, tx_tlp_end_out, lcrc_bit0_invert, stp_len_valid, prefix_parity_fault;
  logic pre_seq_parity_fault, post_seq_parity_fault, post_seq_parity_nullify, post_seq_parity_report;
  logic replay_single_flip, replay_double_flip, replay_single_correct, replay_err_nullify;
  logic replay_double_report, replay_single_report, rx_tlp_accept, rx_acknak_accept;
  logic rx_early_forward_en, ack_double_rate;
  int n_mismatch = 0;
  int compares = 0;
  localparam int IBIT [8] = '{PFX_PAR_BIT, PRE_ARM_BIT, POST_ARM_BIT, GAP_BIT, MALF_BIT, LCRC_BIT,
                              DBL_ARM_BIT, SGL_ARM_BIT};
  localparam logic [31:0] ECTL [7] = '{0, 32'h0000_6000, 0, 32'h0000_0060, 0, 32'h0000_0002, 32'h0000_0004};
  localparam logic [7:0] ESTIM [7] = '{8'h04, 8'h04, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01};
  localparam logic [5:0] EEXP [7] = '{6'h30, 6'h00, 6'h06, 6'h00, 6'h09, 6'h06, 6'h08};

  // Free-running 40 MHz clock
  always #12.5 hclk = ~hclk;
  // One vector carries every stream opportunity and error pulse
  assign {tx_tlp_start, tx_tlp_end, tx_in_tlp, tx_word_valid_in, replay_ram_write, post_seq_parity_err,
          replay_double_err, replay_single_err} = stim;

  pcdl_ahb_host u_host (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata);
  pcdl_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .link_rate, .link_up_indication, .tx_tlp_start, .tx_tlp_end, .tx_in_tlp,
    .tx_word_valid_in, .tx_hdr_dw, .tx_payload_dw, .tx_ecrc_present, .link_tx_word_valid, .tx_tlp_end_out,
    .lcrc_bit0_invert, .stp_len_field, .stp_len_valid, .prefix_parity_fault, .pre_seq_parity_fault,
    .post_seq_parity_fault, .post_seq_parity_err, .post_seq_parity_nullify, .post_seq_parity_report,
    .replay_ram_write, .replay_single_flip, .replay_double_flip, .replay_single_err, .replay_double_err,
    .replay_single_correct, .replay_err_nullify, .replay_double_report, .replay_single_report, .rx_tlp_valid,
    .rx_tlp_seq, .rx_tlp_accept, .rx_tlp_seq_out, .rx_acknak_valid, .rx_acknak_accept, .rx_early_forward_en,
    .ack_double_rate);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  // Framed length: token, 4-dword header, payload, ECRC, LCRC
  function automatic logic [10:0] flen(input logic [10:0] p);
    return 11'd1 + 11'd4 + p + 11'd1 + 11'd1;
  endfunction : flen

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0000_0000, rd);
    chk(nm, rd, exp);
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask : rdc
  // One-cycle stimulus beat; strobes sampled mid-cycle
  task automatic beat(input logic [7:0] s);
    @(posedge hclk);
    stim <= s;
    @(negedge hclk);
    inj = {prefix_parity_fault, pre_seq_parity_fault, post_seq_parity_fault, !link_tx_word_valid,
           !tx_tlp_end_out, lcrc_bit0_invert, replay_double_flip, replay_single_flip};
    errv = {post_seq_parity_nullify, post_seq_parity_report, replay_single_correct, replay_err_nullify,
            replay_double_report, replay_single_report};
    @(posedge hclk);
    stim <= 8'h00;
  endtask : beat
  task automatic stp(input pcdl_rate_type r, input logic [10:0] p, input logic [10:0] exp, input logic ev);
    link_rate <= r;
    tx_payload_dw <= p;
    beat(8'h80);
    @(negedge hclk);
    chk("stp_valid", {31'h0, stp_len_valid}, {31'h0, ev});
    if (ev)
      chk("stp_len", {21'h0, stp_len_field}, {21'h0, exp});
    @(posedge hclk); // Next stimulus change lands on a rising edge
  endtask : stp
  task automatic rx(input logic [31:0] c, input logic up, input logic [1:0] ea, input logic [11:0] inc);
    wr(OFS_CTRL, c);
    rnd = lfsr(rnd);
    link_up_indication <= up;
    rx_tlp_seq <= rnd[11:0];
    @(negedge hclk);
    chk("rx_accept", {30'h0, rx_tlp_accept, rx_acknak_accept}, {30'h0, ea});
    chk("rx_seq", {20'h0, rx_tlp_seq_out}, {20'h0, rnd[11:0] + inc});
  endtask : rx
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Watchdog against a hung bus or bench
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial begin
    stim = 8'h00;
    link_rate = RATE_2G5;
    link_up_indication = 1'b1;
    tx_hdr_dw = 3'h4;
    tx_payload_dw = 11'h000;
    tx_ecrc_present = 1'b1;
    rx_tlp_valid = 1'b0;
    rx_acknak_valid = 1'b0;
    rx_tlp_seq = 12'h000;
    rnd = 32'hfdb4_e825;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("rst_ack", OFS_ACK, RST_ACK);
    rdc("rst_tx", OFS_TX, RST_TX);
    rdc("rst_ctrl", OFS_CTRL, RST_CTRL);
    rdc("rst_stat", OFS_STAT, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(OFS_ACK, rnd);
      wr(OFS_CTRL, ~rnd);
      rdc("ack_reg", OFS_ACK, rnd & MASK_ACK);
      rdc("ctrl_reg", OFS_CTRL, ~rnd & MASK_CTRL);
      chk("ack_rate", {31'h0, ack_double_rate}, {31'h0, rnd[ACK_RATE_BIT]});
      chk("early_fwd", {31'h0, rx_early_forward_en}, {31'h0, rnd[EARLY_FWD_OFF_BIT]});
    end
    wr(12'h388, rnd);
    rdc("unmapped", 12'h388, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
    beat(8'hF8); // Flush requests armed by the random writes
    $display("done: registers");
    for (int k = 0; k < 8; k++) begin
      wr(OFS_CTRL, 32'h0000_0001 << IBIT[k]);
      beat(8'hF8);
      chk("inject", {24'h0, inj}, 32'h0000_0080 >> k);
      beat(8'hF8);
      chk("one_shot", {24'h0, inj}, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0000);
    end
    $display("done: injectors");
    for (int k = 0; k < 7; k++) begin
      wr(OFS_CTRL, ECTL[k]);
      beat(ESTIM[k]);
      chk("err_handling", {26'h0, errv}, {26'h0, EEXP[k]});
    end
    wr(OFS_STAT, 32'h0008_0000);
    wr(OFS_CTRL, 32'h0000_4000);
    beat(8'h04);
    rdc("stat_quiet", OFS_STAT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0000);
    beat(8'h04);
    rdc("stat_set", OFS_STAT, 32'h0008_0000);
    wr(OFS_STAT, 32'h0008_0000);
    rdc("stat_clear", OFS_STAT, 32'h0000_0000);
    $display("done: error handling");
    rnd = lfsr(rnd);
    nw = rnd[26:16];
    stp(RATE_8G, {1'b0, rnd[9:0]}, flen({1'b0, rnd[9:0]}), 1'b1);
    wr(OFS_TX, {1'b1, 4'h0, nw, 5'h00, flen({1'b0, rnd[9:0]})});
    rdc("tx_reg", OFS_TX, {1'b1, 4'h0, nw, 5'h00, flen({1'b0, rnd[9:0]})});
    stp(RATE_2G5, {1'b0, rnd[9:0]}, 11'h000, 1'b0);
    stp(RATE_5G, {1'b0, rnd[9:0]}, 11'h000, 1'b0);
    stp(RATE_8G, {1'b0, rnd[9:0]} + 11'h001, flen({1'b0, rnd[9:0]} + 11'h001), 1'b1);
    stp(RATE_16G, {1'b0, rnd[9:0]}, nw, 1'b1);
    stp(RATE_8G, {1'b0, rnd[9:0]}, flen({1'b0, rnd[9:0]}), 1'b1);
    $display("done: framing length");
    rx_tlp_valid <= 1'b1;
    rx_acknak_valid <= 1'b1;
    rx(32'h0000_0000, 1'b0, 2'b01, 12'h000);
    rx(32'h0000_0000, 1'b1, 2'b11, 12'h000);
    rx(32'h0004_0000, 1'b0, 2'b11, 12'h000);
    rx(32'h0002_0000, 1'b1, 2'b11, 12'h001);
    rx(32'h0001_0000, 1'b1, 2'b10, 12'h000);
    $display("done: receive path");
    wrap_up();
  end
endmodule : pcdl_ctrl_tb
